// [src/ehps_bank.sv]
// Route ownership register and four root port registers
`timescale 1ns/1ps
`include "ehps_regs.svh"
module ehps_bank
  import ehps_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_ind_supported,
  input  wire logic [3:0]  i_connect,
  input  wire logic [3:0]  i_overcurrent,
  input  wire logic [7:0]  i_line_state,
  output logic      [31:0] o_rdata,
  output logic      [3:0]  o_route_highspeed,
  output logic      [3:0]  o_wake,
  output logic      [27:0] o_test
);
  logic       route_r;
  logic       route_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [3:0] con_s1_r;
  logic [3:0] con_s2_r;
  logic [3:0] oc_s1_r;
  logic [3:0] oc_s2_r;
  logic [7:0] ls_s1_r;
  logic [7:0] ls_s2_r;
  logic [31:0] port_rdata [0:`EHPS_NUM_PORTS-1];
  logic [3:0] port_owner;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      con_s1_r <= 4'h0;
      con_s2_r <= 4'h0;
      oc_s1_r  <= 4'h0;
      oc_s2_r  <= 4'h0;
      ls_s1_r  <= 8'h00;
      ls_s2_r  <= 8'h00;
    end else begin
      con_s1_r <= i_connect;
      con_s2_r <= con_s1_r;
      oc_s1_r  <= i_overcurrent;
      oc_s2_r  <= oc_s1_r;
      ls_s1_r  <= i_line_state;
      ls_s2_r  <= ls_s1_r;
    end
  end

  always_comb begin
    route_nxt = route_r;
    if (i_wr && i_addr == `EHPS_OFS_ROUTE)
      route_nxt = i_wdata[`EHPS_BIT_ROUTE];
    rdata_nxt = 32'h0000_0000;
    if (i_rd) begin
      if (i_addr == `EHPS_OFS_ROUTE)
        rdata_nxt = {31'h0000_0000, route_r};
      for (int k = 0; k < `EHPS_NUM_PORTS; k++) begin
        if (i_addr == `EHPS_OFS_PORT0 + 8'(4 * k))
          rdata_nxt = port_rdata[k];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      route_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      route_r <= route_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `EHPS_NUM_PORTS; g++) begin : gen_port
      ehps_port u_port (
        .i_clk           (i_clk),
        .i_resetn        (i_resetn),
        .i_wr            (i_wr && i_addr == `EHPS_OFS_PORT0 + 8'(4 * g)),
        .i_wdata         (i_wdata),
        .i_ind_supported (i_ind_supported),
        .i_connect       (con_s2_r[g]),
        .i_overcurrent   (oc_s2_r[g]),
        .i_line_state    (ls_s2_r[2*g+1:2*g]),
        .i_route_rise    (route_nxt & ~route_r),
        .o_rdata         (port_rdata[g]),
        .o_wake          (o_wake[g]),
        .o_test          (o_test[7*g+6:7*g])
      );
      assign port_owner[g] = port_rdata[g][`EHPS_BIT_OWNER];
      // Owner bit hands a port back to the classic side
      assign o_route_highspeed[g] = route_r & ~port_owner[g];
    end
  endgenerate

  assign o_rdata = rdata_r;
endmodule

// [src/ehps_pkg.sv]
// Types shared by the routing and port register bank
package ehps_pkg;
  typedef enum logic [6:0] {
    EHPS_TEST_NONE   = 7'b0000001,
    EHPS_TEST_J      = 7'b0000010,
    EHPS_TEST_K      = 7'b0000100,
    EHPS_TEST_SE0NAK = 7'b0001000,
    EHPS_TEST_PACKET = 7'b0010000,
    EHPS_TEST_FORCE  = 7'b0100000,
    EHPS_TEST_RSVD   = 7'b1000000
  } ehps_test_t;
endpackage

// [src/ehps_port.sv]
// One root port status and control register
`timescale 1ns/1ps
`include "ehps_regs.svh"
module ehps_port
  import ehps_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_wr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_ind_supported,
  input  wire logic        i_connect,
  input  wire logic        i_overcurrent,
  input  wire logic [1:0]  i_line_state,
  input  wire logic        i_route_rise,
  output logic      [31:0] o_rdata,
  output logic             o_wake,
  output ehps_test_t       o_test
);
  logic [31:0] reg_r;
  logic [31:0] reg_nxt;
  logic        con_d_r;
  logic        oc_d_r;
  logic        con_rise;
  logic        con_fall;
  logic        oc_rise;

  assign con_rise = i_connect & ~con_d_r;
  assign con_fall = ~i_connect & con_d_r;
  assign oc_rise  = i_overcurrent & ~oc_d_r;

  always_comb begin
    reg_nxt = reg_r;
    reg_nxt[31:23] = 9'h000;
    reg_nxt[9] = 1'b0;
    if (i_wr) begin
      reg_nxt[`EHPS_BIT_POWER] = i_wdata[`EHPS_BIT_POWER];
      reg_nxt[`EHPS_BIT_WK_OC:`EHPS_BIT_WK_ATT] = i_wdata[`EHPS_BIT_WK_OC:`EHPS_BIT_WK_ATT];
      if (reg_r[`EHPS_BIT_POWER]) begin
        reg_nxt[`EHPS_PTC_HI:`EHPS_PTC_LO] = i_wdata[`EHPS_PTC_HI:`EHPS_PTC_LO];
        reg_nxt[`EHPS_BIT_OWNER] = i_wdata[`EHPS_BIT_OWNER];
        reg_nxt[`EHPS_BIT_RESET] = i_wdata[`EHPS_BIT_RESET];
        reg_nxt[`EHPS_BIT_PORT_SUSPEND_BIT]  = i_wdata[`EHPS_BIT_PORT_SUSPEND_BIT];
        reg_nxt[`EHPS_BIT_FRES]  = i_wdata[`EHPS_BIT_FRES];
        if (!i_wdata[`EHPS_BIT_EN])
          reg_nxt[`EHPS_BIT_EN] = 1'b0;
        if (i_ind_supported)
          reg_nxt[`EHPS_PIC_HI:`EHPS_PIC_LO] = i_wdata[`EHPS_PIC_HI:`EHPS_PIC_LO];
      end
      if (i_wdata[`EHPS_BIT_OCC])  reg_nxt[`EHPS_BIT_OCC]  = 1'b0;
      if (i_wdata[`EHPS_BIT_ENC])  reg_nxt[`EHPS_BIT_ENC]  = 1'b0;
      if (i_wdata[`EHPS_BIT_CONC]) reg_nxt[`EHPS_BIT_CONC] = 1'b0;
    end
    // Routing bit set: port defaults to the high-speed side
    if (i_route_rise) reg_nxt[`EHPS_BIT_OWNER] = 1'b0;
    // Hardware events win over a clearing write
    reg_nxt[`EHPS_BIT_CON] = i_connect;
    reg_nxt[`EHPS_BIT_OCA] = i_overcurrent;
    reg_nxt[`EHPS_LS_HI:`EHPS_LS_LO] = i_line_state;
    if (con_rise | con_fall) reg_nxt[`EHPS_BIT_CONC] = 1'b1;
    if (oc_rise) reg_nxt[`EHPS_BIT_OCC] = 1'b1;
    if (con_fall | oc_rise) begin
      if (reg_r[`EHPS_BIT_EN]) reg_nxt[`EHPS_BIT_ENC] = 1'b1;
      reg_nxt[`EHPS_BIT_EN] = 1'b0;
    end
    if (reg_r[`EHPS_BIT_RESET] && !reg_nxt[`EHPS_BIT_RESET] && i_connect)
      reg_nxt[`EHPS_BIT_EN] = 1'b1;
  end

  // Auxiliary well: cleared only by aux power-up or controller reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reg_r   <= `EHPS_PORT_RESET_VAL;
      con_d_r <= 1'b0;
      oc_d_r  <= 1'b0;
    end else begin
      reg_r   <= reg_nxt;
      con_d_r <= i_connect;
      oc_d_r  <= i_overcurrent;
    end
  end

  always_comb begin
    case (reg_r[`EHPS_PTC_HI:`EHPS_PTC_LO])
      4'h0:    o_test = EHPS_TEST_NONE;
      4'h1:    o_test = EHPS_TEST_J;
      4'h2:    o_test = EHPS_TEST_K;
      4'h3:    o_test = EHPS_TEST_SE0NAK;
      4'h4:    o_test = EHPS_TEST_PACKET;
      4'h5:    o_test = EHPS_TEST_FORCE;
      default: o_test = EHPS_TEST_RSVD;
    endcase
  end

  assign o_rdata = reg_r;
  assign o_wake  = (reg_r[`EHPS_BIT_WK_ATT] & con_rise) | (reg_r[`EHPS_BIT_WK_DET] & con_fall)
                 | (reg_r[`EHPS_BIT_WK_OC] & oc_rise);
endmodule

// [src/ehps_regs.svh]
// Offsets, field positions, port count and reset values for the routing and port registers
// Contract
// - Routing bit zero hands every root port to a classic companion controller.
// - Routing bit one routes every root port whose owner bit is clear to the high-speed controller.
// - Port registers live in the auxiliary power domain and survive main power loss.
// - Port registers reset only on auxiliary power-up or host controller reset.
// - After reset each port shows no device attached and disabled.
// - Without port power set, port state changes are ignored; software sets power first (code still reports connect, overcurrent and line state changes).
// - Four port registers, ports 1 to 4, consecutive words from offset 64h.
// - Set wake enables make overcurrent, detach or attach events wake-up events.
// - Test field decodes none, J, K, SE0_NAK, packet, force enable; rest reserved.
// - Indicator field writes are ignored when indicator support is not reported.
`ifndef EHPS_REGS_SVH
`define EHPS_REGS_SVH
`define EHPS_OFS_ROUTE       8'h60
`define EHPS_OFS_PORT0       8'h64
`define EHPS_NUM_PORTS       4
`define EHPS_BIT_ROUTE       0
`define EHPS_BIT_WK_OC       22
`define EHPS_BIT_WK_DET      21
`define EHPS_BIT_WK_ATT      20
`define EHPS_PTC_HI          19
`define EHPS_PTC_LO          16
`define EHPS_PIC_HI          15
`define EHPS_PIC_LO          14
`define EHPS_BIT_OWNER       13
`define EHPS_BIT_POWER       12
`define EHPS_LS_HI           11
`define EHPS_LS_LO           10
`define EHPS_BIT_RESET       8
`define EHPS_BIT_PORT_SUSPEND_BIT        7
`define EHPS_BIT_FRES        6
`define EHPS_BIT_OCC         5
`define EHPS_BIT_OCA         4
`define EHPS_BIT_ENC         3
`define EHPS_BIT_EN          2
`define EHPS_BIT_CONC        1
`define EHPS_BIT_CON         0
`define EHPS_PORT_RESET_VAL  32'h0000_2000
`define EHPS_ROUTE_RESET_VAL 32'h0000_0000
`endif

// [verification/ehps_bank_checker.sv]
// Assertions on the route and port register bank
`timescale 1ns/1ps
module ehps_bank_checker (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input wire logic [3:0]  o_route_highspeed,
  input wire logic [3:0]  o_wake,
  input wire logic [27:0] o_test
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_rst; $rose(i_resetn) |-> o_route_highspeed == 4'h0 && o_wake == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_cf0; i_wr && i_addr == 8'h60 && !i_wdata[0] |=> o_route_highspeed == 4'h0; endproperty
  a_cf0: assert property (p_cf0) else $error("route not classic");
  property p_cf1; i_wr && i_addr == 8'h60 ##1 i_rd && i_addr == 8'h60 |=> o_rdata == ($past(i_wdata, 2) & 32'h1);
  endproperty
  a_cf1: assert property (p_cf1) else $error("route readback");
  property p_chg; $changed(o_route_highspeed) |-> $past(i_wr); endproperty
  a_chg: assert property (p_chg) else $error("route moved alone");
  property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data held");
  property p_unm; i_rd && (i_addr < 8'h60 || i_addr > 8'h70 || i_addr[1:0] != 2'h0) |=> o_rdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_rsv; i_rd && i_addr inside {8'h64, 8'h68, 8'h6C, 8'h70} |=> o_rdata[31:23] == 9'h0 && !o_rdata[9];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_oh; $onehot(o_test[6:0]) && $onehot(o_test[13:7]) && $onehot(o_test[20:14])
    && $onehot(o_test[27:21]); endproperty
  a_oh: assert property (p_oh) else $error("test decode");
  property p_tdec; i_rd && !i_wr && i_addr == 8'h64
    |=> o_test[6:0] == (o_rdata[19:16] < 4'h6 ? 7'h01 << o_rdata[19:16] : 7'h40); endproperty
  a_tdec: assert property (p_tdec) else $error("test decode vs field");
endmodule
bind ehps_bank ehps_bank_checker i_ehps_bank_checker (.*);

// [verification/ehps_bank_tb_top.sv]
// Self-checking bench for the route and port register bank
`timescale 1ns/1ps
module ehps_bank_tb_top;
  logic        i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, ind = 0;
  logic [7:0]  i_addr = 8'h00, ls;
  logic [31:0] i_wdata = 32'h0, rdat;
  logic [3:0]  att = 4'h0, flt = 4'h0, oc, hs, wk;
  logic [27:0] tst;
  int          fails = 0, n_checks = 0, cyc = 0, mr = 0, k, m[4] = '{4{32'h2000}};
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc == 5000) end_of_test(1);
  ehps_dev_model i_ehps_dev_model (.i_attach(att), .i_fault(flt), .o_overcurrent(oc), .o_line_state(ls));
  ehps_bank i_ehps_bank (.i_clk(i_clk), .i_resetn(i_resetn), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_ind_supported(ind), .i_connect(att), .i_overcurrent(oc), .i_line_state(ls),
    .o_rdata(rdat), .o_route_highspeed(hs), .o_wake(wk), .o_test(tst));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    fails += (g !== e);
    if (g !== e) $display("CHECK FAILED %s exp %h got %h", n, e, g);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    logic [31:0] wm;
    if (a == 8'h60) begin
      if (v[0] && !mr[0]) for (int p = 0; p < 4; p++) m[p][13] = 1'b0;
      mr = v[0];
    end else begin
      k = (a - 8'h64) >> 2;
      wm = m[k][12] ? (ind ? 32'h007FF000 : 32'h007F3000) : 32'h00701000;
      m[k] = (m[k] & ~wm) | (v & wm);
    end
    {i_wr, i_rd, i_addr, i_wdata} = {2'b10, a, v};
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    {i_wr, i_rd, i_addr} = {2'b01, a};
    @(posedge i_clk);
    #1;
  endtask
  task automatic scan(logic [31:0] msk);
    logic [27:0] te, he;
    rd(8'h60);
    chk("route_cfg", mr, rdat);
    for (int p = 0; p < 4; p++) begin
      rd(8'h64 + 8'(4 * p));
      chk("port", m[p] & msk, rdat & msk);
      he[p] = mr[0] & ~m[p][13];
      te[7*p+:7] = m[p][19:16] < 6 ? 7'h01 << m[p][19:16] : 7'h40;
    end
    chk("route", 32'(he[3:0]), 32'(hs));
    chk("test", 32'(te), 32'(tst));
    rd(8'h74);
    chk("unmapped", 32'h0, rdat);
  endtask
  task automatic end_of_test(int to);
    fails += to;
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(77));
    repeat (2) @(posedge i_clk);
    #1 i_resetn = 1;
    scan(32'hFFFFFFFF);
    for (int i = 0; i < 60; i++) begin
      ind = 1'($urandom);
      k = $urandom % 4;
      wr(8'h64 + 8'(4 * k), $urandom & 32'h007FF000);
      if ($urandom % 4 == 0) wr(8'h60, $urandom % 2);
      scan(32'h007FF001);
    end
    wr(8'h64, 32'h00001000);
    wr(8'h6C, 32'h00001000);
    i_wr = 0;
    repeat (4) @(posedge i_clk) #1;
    wr(8'h64, 32'h00101000);
    wr(8'h6C, 32'h00401000);
    rd(8'h60);
    {att, flt} = 8'h14;
    for (int n = 0; n < 10 && wk === 4'h0; n++) @(posedge i_clk) #1;
    chk("wake", 32'h5, 32'(wk));
    m[0] |= 32'h803;
    m[2] |= 32'h30;
    scan(32'h00000C3F);
    wr(8'h64, (m[0] & 32'h007FF000) | 32'h2);
    m[0] &= ~32'h2;
    scan(32'h00000C3F);
    {att, flt} = 8'h00;
    #40 i_resetn = 0;
    mr = 0;
    m = '{4{32'h2000}};
    #40 i_resetn = 1;
    scan(32'hFFFFFFFF);
    end_of_test(0);
  end
endmodule

// [verification/ehps_dev_model.sv]
// Downstream device model for the four root ports
`timescale 1ns/1ps
module ehps_dev_model (
  input  wire logic [3:0] i_attach,
  input  wire logic [3:0] i_fault,
  output logic      [3:0] o_overcurrent,
  output logic      [7:0] o_line_state
);
  always_comb begin
    o_overcurrent = i_fault;
    for (int p = 0; p < 4; p++) o_line_state[2*p+:2] = i_attach[p] ? 2'b10 : 2'b00;
  end
endmodule
